// file: logic/ext_decoder_regs.svh
// Purpose: Register offsets, opcode fields and timing constants of the decoder
// Assumes: Byte addresses on a 32-bit APB, one word per register
// Notes: Definitions only
`ifndef EXT_DECODER_REGS_SVH
`define EXT_DECODER_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_INSTR 8'h04
`define REG_INSTR2 8'h08
`define REG_WORKING_REGISTER 8'h0c
`define REG_BSR 8'h10
`define REG_STATUS 8'h14
`define REG_FSR0 8'h18
`define REG_FSR1 8'h1c
`define REG_POINTER_TWO 8'h20
`define REG_PC 8'h24
`define REG_TOS 8'h28
`define REG_PCLAT 8'h2c
`define REG_MEM_ADDR 8'h30
`define REG_MEM_DATA 8'h34
`define REG_EXEC 8'h38
`define REG_LAST 8'h38

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_EXT_BIT 0
`define CTRL_RESET 1'h0
`define INSTR_RESET 16'h0000
`define OP_XOR_W_WITH_FILE 6'h06
`define OP_EXT_GROUP 6'h3a
`define EXT_ADD 2'h0
`define EXT_SUB 2'h1
`define EXT_PUSH 2'h2
`define EXT_MOVE 2'h3
`define SEL_RETURN 2'h3
`define SEL_POINTER2 2'h2
`define OP_CALL_VIA_WORKING_REG 16'h0014
`define SECOND_WORD 4'hf
`define ACCESS_SPLIT 8'h5f
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hf
`define INDIRECT_LO 12'hfdb
`define INDIRECT_HI 12'hfef

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define Q_PHASES 4'h4
`define PC_STEP 2
`endif

// file: logic/ext_decoder_pkg.sv
// Purpose: Types shared by the extended instruction decoder
// Assumes: Nothing
// Notes: Constants live in ext_decoder_regs.svh
package ext_decoder_pkg;

	typedef enum logic {ST_IDLE, ST_RUN} exec_state_t;

	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} status_flags_t;

	typedef struct packed {
		logic [4:0] upper;
		logic [7:0] high;
	} pc_latch_t;

	typedef logic [11:0] data_addr_t;

endpackage : ext_decoder_pkg

// file: logic/extended_instruction_decoder.sv
// Purpose: Executes the xor-with-file and the extended instructions, driven over APB
// Assumes: Single clock, one instruction cycle is Q_PHASES clocks, APB3 slave
// Notes: Writing the instruction register issues an instruction; APB stalls until done
// Behaviour
// - xor-with-file opcode xors working register with addressed file byte
// - Destination bit 0 writes working register, 1 writes file byte back
// - Access bit 0 uses access bank, 1 uses bank select register
// - Extension on, access 0, address up to 5Fh: pointer two plus offset
// - Xor takes one word, one cycle, changes only negative and zero flags
// - Extension off after reset; enabled only by setting the enable bit
// - Standard set kept, eight extra instructions only while extension enabled
// - Pointer add and subtract take one cycle, adjust pointer by k, no flags
// - Select field 11 acts on pointer two then returns, taking two cycles
// - Call via working register: two cycles, target from PC latch and working register, no flags
// - Indexed moves: two words, two cycles, bit 7 picks form, word two 1111
// - Push literal stores k at pointer two then decrements it, one cycle
// - Pointer add adds six-bit literal to full selected pointer contents
// - Indexed move reading an indirect register address yields zero
`timescale 1ns/10ps
`include "ext_decoder_regs.svh"

module extended_instruction_decoder import ext_decoder_pkg::*; #(
	parameter int ADDR_W = 8,
	parameter int DATA_AW = 12,
	parameter int PC_W = 21
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic ext_en_q;
	logic [15:0] instr_q;
	logic [15:0] instr2_q;
	logic [7:0] w_q;
	logic [3:0] bsr_q;
	status_flags_t status_q;
	data_addr_t fsr_q [0:2];
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] tos_q;
	pc_latch_t pclat_q;
	data_addr_t mem_addr_q;
	logic unsupported_q;
	logic last_two_q;
	exec_state_t state_q;
	logic [3:0] cnt_q;
	logic ready_q;
	logic [31:0] prdata_q;
	logic [7:0] mem_q [0:(1<<DATA_AW)-1];

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	wire busy = (state_q == ST_RUN);
	wire access = psel && penable;
	wire mapped = (paddr[1:0] == 2'h0) && (paddr <= `REG_LAST);
	wire wr_take = access && pwrite && ready_q;
	wire wr_ctrl = wr_take && (paddr == `REG_CTRL);
	wire start = wr_take && (paddr == `REG_INSTR);
	wire wr_instr2 = wr_take && (paddr == `REG_INSTR2);
	wire wr_w = wr_take && (paddr == `REG_WORKING_REGISTER);
	wire wr_bsr = wr_take && (paddr == `REG_BSR);
	wire wr_status = wr_take && (paddr == `REG_STATUS);
	wire wr_pc = wr_take && (paddr == `REG_PC);
	wire wr_tos = wr_take && (paddr == `REG_TOS);
	wire wr_pclat = wr_take && (paddr == `REG_PCLAT);
	wire wr_maddr = wr_take && (paddr == `REG_MEM_ADDR);
	wire wr_mdata = wr_take && (paddr == `REG_MEM_DATA);
	wire [2:0] wr_fsr = {wr_take && (paddr == `REG_POINTER_TWO), wr_take && (paddr == `REG_FSR1),
		wr_take && (paddr == `REG_FSR0)};

	// ------------------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------------------
	wire [7:0] f_field = instr_q[7:0];
	wire a_bit = instr_q[8];
	wire d_bit = instr_q[9];
	wire [1:0] ext_op = instr_q[9:8];
	wire [1:0] sel_field = instr_q[7:6];
	wire [5:0] k6 = instr_q[5:0];
	wire is_xor = (instr_q[15:10] == `OP_XOR_W_WITH_FILE);
	wire ext_group = ext_en_q && (instr_q[15:10] == `OP_EXT_GROUP);
	wire is_padd = ext_group && (ext_op == `EXT_ADD);
	wire is_psub = ext_group && (ext_op == `EXT_SUB);
	wire is_push = ext_group && (ext_op == `EXT_PUSH);
	wire is_move = ext_group && (ext_op == `EXT_MOVE) && (instr2_q[15:12] == `SECOND_WORD);
	wire is_move_indexed_to_indexed = is_move && instr_q[7];
	wire is_call_via_working_reg = ext_en_q && (instr_q == `OP_CALL_VIA_WORKING_REG);
	wire is_ret = (is_padd || is_psub) && (sel_field == `SEL_RETURN);
	wire two_cycle = is_ret || is_call_via_working_reg || is_move;
	wire known = is_xor || is_padd || is_psub || is_push || is_move || is_call_via_working_reg;

	// ------------------------------------------------------------------------
	// Address generation
	// ------------------------------------------------------------------------
	wire low_half = (f_field <= `ACCESS_SPLIT);
	wire indexed = ext_en_q && !a_bit && low_half;
	wire [11:0] access_addr = low_half ? {`ACCESS_LOW_BANK, f_field} :
		{`ACCESS_HIGH_BANK, f_field};
	wire [11:0] byte_addr = a_bit ? {bsr_q, f_field} :
		indexed ? (fsr_q[2] + {4'h0, f_field}) : access_addr;
	wire [7:0] file_byte = mem_q[byte_addr];
	wire [7:0] xor_res = w_q ^ file_byte;

	wire [1:0] ptr_sel = is_ret ? `SEL_POINTER2 : sel_field;
	wire [11:0] ptr_cur = fsr_q[ptr_sel];
	wire [11:0] ptr_new = is_psub ? (ptr_cur - {6'h00, k6}) : (ptr_cur + {6'h00, k6});

	wire [11:0] src_addr = fsr_q[2] + {5'h00, instr_q[6:0]};
	wire src_indirect = (src_addr >= `INDIRECT_LO) && (src_addr <= `INDIRECT_HI);
	wire [7:0] src_byte = src_indirect ? 8'h00 : mem_q[src_addr];
	wire [11:0] dst_addr = is_move_indexed_to_indexed ? (fsr_q[2] + {5'h00, instr2_q[6:0]}) : instr2_q[11:0];

	wire [PC_W-1:0] pc_step = is_move ? PC_W'(2 * `PC_STEP) : PC_W'(`PC_STEP);
	wire [PC_W-1:0] pc_seq = pc_q + pc_step;
	wire [PC_W-1:0] call_target = PC_W'({pclat_q, w_q});
	wire [PC_W-1:0] pc_next = is_ret ? tos_q : is_call_via_working_reg ? call_target : pc_seq;

	// ------------------------------------------------------------------------
	// Execution sequencing
	// ------------------------------------------------------------------------
	wire [3:0] run_len = two_cycle ? (`Q_PHASES + `Q_PHASES) : `Q_PHASES;
	wire commit = busy && (cnt_q == 4'h1);
	wire load_len = busy && (cnt_q == 4'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: if (start) state_q <= ST_RUN;
				ST_RUN: if (commit) state_q <= ST_IDLE;
			endcase
			cnt_q <= load_len ? (run_len - 4'h1) : (busy ? cnt_q - 4'h1 : 4'h0);
		end
	end

	// ------------------------------------------------------------------------
	// Core registers
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_en_q <= `CTRL_RESET;
			instr_q <= `INSTR_RESET;
			instr2_q <= `INSTR_RESET;
			bsr_q <= 4'h0;
			pclat_q <= '0;
			mem_addr_q <= '0;
		end else begin
			if (wr_ctrl) ext_en_q <= pwdata[`CTRL_EXT_BIT];
			if (start) instr_q <= pwdata[15:0];
			if (wr_instr2) instr2_q <= pwdata[15:0];
			if (wr_bsr) bsr_q <= pwdata[3:0];
			if (wr_pclat) pclat_q <= pwdata[12:0];
			if (wr_maddr) mem_addr_q <= pwdata[11:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_q <= 8'h00;
			status_q <= '0;
		end else begin
			if (wr_w) w_q <= pwdata[7:0];
			else if (commit && is_xor && !d_bit) w_q <= xor_res;
			if (wr_status) status_q <= pwdata[4:0];
			else if (commit && is_xor) begin
				status_q.n <= xor_res[7];
				status_q.z <= (xor_res == 8'h00);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= '0;
			tos_q <= '0;
			unsupported_q <= 1'b0;
			last_two_q <= 1'b0;
		end else begin
			if (wr_pc) pc_q <= pwdata[PC_W-1:0];
			else if (commit) pc_q <= pc_next;
			if (wr_tos) tos_q <= pwdata[PC_W-1:0];
			else if (commit && is_call_via_working_reg) tos_q <= pc_q + PC_W'(`PC_STEP);
			if (commit) unsupported_q <= !known;
			if (commit) last_two_q <= two_cycle;
		end
	end

	genvar gi;
	for (gi = 0; gi < 3; gi++) begin : g_fsr
		wire ptr_hit = commit && (is_padd || is_psub) && (ptr_sel == 2'(gi));
		wire push_hit = commit && is_push && (gi == 2);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) fsr_q[gi] <= '0;
			else if (wr_fsr[gi]) fsr_q[gi] <= pwdata[11:0];
			else if (ptr_hit) fsr_q[gi] <= ptr_new;
			else if (push_hit) fsr_q[gi] <= fsr_q[gi] - 12'h001;
		end
	end

	// ------------------------------------------------------------------------
	// Data memory
	// ------------------------------------------------------------------------
	wire exec_we = commit && ((is_xor && d_bit) || is_move || is_push);
	wire mem_we = exec_we || wr_mdata;
	wire [11:0] mem_wa = wr_mdata ? mem_addr_q : is_push ? fsr_q[2] :
		is_move ? dst_addr : byte_addr;
	wire [7:0] mem_wd = wr_mdata ? pwdata[7:0] : is_push ? f_field :
		is_move ? src_byte : xor_res;

	always_ff @(posedge pclk) begin
		if (mem_we) mem_q[mem_wa] <= mem_wd;
	end

	// ------------------------------------------------------------------------
	// APB read path and handshake
	// ------------------------------------------------------------------------
	wire [31:0] rd_mux =
		(paddr == `REG_CTRL) ? {31'h0, ext_en_q} :
		(paddr == `REG_INSTR) ? {16'h0, instr_q} :
		(paddr == `REG_INSTR2) ? {16'h0, instr2_q} :
		(paddr == `REG_WORKING_REGISTER) ? {24'h0, w_q} :
		(paddr == `REG_BSR) ? {28'h0, bsr_q} :
		(paddr == `REG_STATUS) ? {27'h0, status_q} :
		(paddr == `REG_FSR0) ? {20'h0, fsr_q[0]} :
		(paddr == `REG_FSR1) ? {20'h0, fsr_q[1]} :
		(paddr == `REG_POINTER_TWO) ? {20'h0, fsr_q[2]} :
		(paddr == `REG_PC) ? 32'(pc_q) :
		(paddr == `REG_TOS) ? 32'(tos_q) :
		(paddr == `REG_PCLAT) ? {19'h0, pclat_q} :
		(paddr == `REG_MEM_ADDR) ? {20'h0, mem_addr_q} :
		(paddr == `REG_MEM_DATA) ? {24'h0, mem_q[mem_addr_q]} :
		(paddr == `REG_EXEC) ? {29'h0, last_two_q, unsupported_q, busy} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			ready_q <= access && !busy && !ready_q;
			if (access && !busy && !ready_q) prdata_q <= rd_mux;
		end
	end

	assign pready = access && ready_q;
	assign pslverr = access && ready_q && !mapped;
	assign prdata = prdata_q;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	a_xor_to_w: assert property (@(posedge pclk) disable iff (!presetn)
		commit && is_xor && !d_bit |=> w_q == $past(w_q ^ file_byte))
		else $error("xor result not placed in working register");

	a_xor_to_file: assert property (@(posedge pclk) disable iff (!presetn)
		commit && is_xor && d_bit |=> w_q == $past(w_q) && mem_q[$past(byte_addr)] == $past(xor_res))
		else $error("xor to file wrong");

	a_bank_select: assert property (@(posedge pclk) disable iff (!presetn)
		busy && is_xor && a_bit |-> byte_addr == {bsr_q, f_field})
		else $error("bank select not used");

	a_access_plain: assert property (@(posedge pclk) disable iff (!presetn)
		busy && !ext_en_q && !a_bit && low_half |-> byte_addr == {4'h0, f_field})
		else $error("access bank address wrong with extension off");

	a_xor_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		start ##1 is_xor |-> busy [*4] ##1 !busy && status_q.c == $past(status_q.c, 2))
		else $error("xor timing or flags wrong");

	a_ext_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		commit && !ext_en_q |=> fsr_q[2] == $past(fsr_q[2]) && pc_q == $past(pc_q) + PC_W'(2))
		else $error("extended behaviour while disabled");

	a_pointer_add: assert property (@(posedge pclk) disable iff (!presetn)
		commit && is_padd && !is_ret |=> fsr_q[$past(sel_field)] ==
			$past(ptr_cur) + {6'h00, $past(k6)} && status_q == $past(status_q))
		else $error("pointer add wrong");

	a_return_two: assert property (@(posedge pclk) disable iff (!presetn)
		start ##1 is_ret |-> busy [*8] ##1 !busy && pc_q == tos_q)
		else $error("return variant timing or target wrong");

	a_call_target: assert property (@(posedge pclk) disable iff (!presetn)
		commit && is_call_via_working_reg |=> tos_q == $past(pc_q) + PC_W'(2) && pc_q[7:0] == $past(w_q))
		else $error("call via working register wrong");

	a_move_zero: assert property (@(posedge pclk) disable iff (!presetn)
		commit && is_move && src_indirect |=> mem_q[$past(dst_addr)] == 8'h00)
		else $error("indirect source not read as zero");

	a_push_literal: assert property (@(posedge pclk) disable iff (!presetn)
		commit && is_push |=> fsr_q[2] == $past(fsr_q[2]) - 12'h001 &&
			mem_q[$past(fsr_q[2])] == $past(f_field))
		else $error("push literal wrong");

endmodule : extended_instruction_decoder

// file: testbench/extended_instruction_decoder_test.sv
// Purpose: Self-checking bench for the xor-with-file and extended instruction decoder
// Assumes: APB slave answers after at least one wait state; memory written before read
// Notes: Reads queue their expected word; a monitor compares at each read answer
`timescale 1ns/10ps
`include "ext_decoder_regs.svh"

module extended_instruction_decoder_test import ext_decoder_pkg::*;;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int error_cnt;
	int n_tests;
	logic [32:0] exp_q[$];
	logic [31:0] seed;
	logic [7:0] w;
	logic [5:0] k;
	logic [11:0] p;

	extended_instruction_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ------------------------------------------------------------------------
	// Clock, bus tasks and result monitor
	// ------------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Pready is sampled at the rising edge, before any update of that edge lands
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) begin
			error_cnt++;
			$display("mismatch t=%0t no pready addr %h", $time, a);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask : rd

	task automatic ex(input logic [15:0] i);
		wr(`REG_INSTR, {16'h0, i});
	endtask : ex

	task automatic mw(input logic [11:0] a, input logic [7:0] d);
		wr(`REG_MEM_ADDR, {20'h0, a});
		wr(`REG_MEM_DATA, {24'h0, d});
	endtask : mw

	task automatic mr(input logic [11:0] a, input logic [7:0] e);
		wr(`REG_MEM_ADDR, {20'h0, a});
		rd(`REG_MEM_DATA, {25'h0, e});
	endtask : mr

	task automatic cmp_read(input logic [32:0] got, input logic [32:0] e);
		n_tests++;
		if (got !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got %h exp %h", $time, got, e);
		end
	endtask : cmp_read

	always @(negedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("mismatch t=%0t got %h exp %h", $time, prdata, 32'h0);
			end else begin
				cmp_read({pslverr, prdata}, exp_q.pop_front());
			end
		end
	end

	task automatic conclude();
		error_cnt += exp_q.size();
		$display("errors %0d comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		#160000;
		error_cnt++;
		conclude();
	end

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		seed = 32'h2eb7544c;
		error_cnt = 0;
		n_tests = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`REG_CTRL, 33'h0);
		rd(`REG_POINTER_TWO, 33'h0);
		rd(8'h3c, {1'b1, 32'h0});
		// Extension off: low address stays in access bank
		w = xs();
		wr(`REG_WORKING_REGISTER, {24'h0, w});
		mw(12'h05f, 8'haf);
		wr(`REG_STATUS, 32'h0b);
		ex(16'h1a5f);
		mr(12'h05f, w ^ 8'haf);
		rd(`REG_WORKING_REGISTER, {25'h0, w});
		rd(`REG_STATUS, {28'h0, (w ^ 8'haf) == 8'h0 ? 5'h0f : {w[7] ^ 1'b1, 4'hb}});
		wr(`REG_WORKING_REGISTER, {24'h0, w ^ 8'haf});
		ex(16'h185f);
		rd(`REG_WORKING_REGISTER, 33'h0);
		rd(`REG_STATUS, 33'h0f);
		rd(`REG_EXEC, 33'h0);
		ex(16'he801);
		rd(`REG_FSR0, 33'h0);
		// Bank select and extension on
		w = xs();
		wr(`REG_WORKING_REGISTER, {24'h0, w});
		wr(`REG_BSR, 32'h3);
		mw(12'h320, 8'h0f);
		ex(16'h1b20);
		mr(12'h320, w ^ 8'h0f);
		wr(`REG_CTRL, 32'h1);
		wr(`REG_POINTER_TWO, 32'h200);
		mw(12'h25f, 8'h55);
		mw(12'hf60, 8'h66);
		ex(16'h1a5f);
		ex(16'h1a60);
		mr(12'h25f, w ^ 8'h55);
		mr(12'hf60, w ^ 8'h66);
		// Pointer add and subtract on each pointer
		wr(`REG_STATUS, 32'h15);
		for (int i = 0; i < 3; i++) begin
			p = xs();
			k = xs();
			wr(`REG_FSR0 + 8'(4 * i), {20'h0, p});
			ex({8'he8, 2'(i), k});
			rd(`REG_FSR0 + 8'(4 * i), {21'h0, p + 12'(k)});
			ex({8'he9, 2'(i), k});
			rd(`REG_FSR0 + 8'(4 * i), {21'h0, p});
			rd(`REG_EXEC, 33'h0);
		end
		// Return variants and call through working register
		wr(`REG_TOS, 32'h1234);
		wr(`REG_POINTER_TWO, 32'h3ff);
		ex(16'he8e3);
		rd(`REG_POINTER_TWO, 33'h422);
		rd(`REG_PC, 33'h1234);
		rd(`REG_EXEC, 33'h4);
		wr(`REG_TOS, 32'h0abc);
		ex(16'he9e3);
		rd(`REG_POINTER_TWO, 33'h3ff);
		rd(`REG_PC, 33'h0abc);
		wr(`REG_PC, 32'h100);
		wr(`REG_PCLAT, 32'h10);
		wr(`REG_WORKING_REGISTER, 32'h06);
		ex(16'h0014);
		rd(`REG_PC, 33'h1006);
		rd(`REG_TOS, 33'h102);
		rd(`REG_EXEC, 33'h4);
		// Literal push
		wr(`REG_POINTER_TWO, 32'h300);
		ex(16'hea5a);
		rd(`REG_POINTER_TWO, 33'h2ff);
		mr(12'h300, 8'h5a);
		rd(`REG_EXEC, 33'h0);
		// Indexed moves
		wr(`REG_POINTER_TWO, 32'h80);
		mw(12'h085, 8'h33);
		mw(12'h124, 8'h77);
		wr(`REG_INSTR2, 32'hf123);
		wr(`REG_PC, 32'h200);
		ex(16'heb05);
		mr(12'h123, 8'h33);
		rd(`REG_PC, 33'h204);
		rd(`REG_EXEC, 33'h4);
		wr(`REG_INSTR2, 32'hf00a);
		ex(16'heb85);
		mr(12'h08a, 8'h33);
		wr(`REG_INSTR2, 32'h0124);
		ex(16'heb05);
		mr(12'h124, 8'h77);
		rd(`REG_EXEC, 33'h2);
		wr(`REG_POINTER_TWO, 32'hfd0);
		wr(`REG_INSTR2, 32'hf124);
		ex(16'heb0b);
		mr(12'h124, 8'h00);
		rd(`REG_STATUS, 33'h15);
		// Extension off again: extended encodings leave state alone
		wr(`REG_CTRL, 32'h0);
		ex(16'hea11);
		rd(`REG_POINTER_TWO, 33'hfd0);
		wr(`REG_PC, 32'h300);
		ex(16'h0014);
		rd(`REG_PC, 33'h302);
		conclude();
	end
endmodule : extended_instruction_decoder_test
